// ### codec_ctrl_pkg.sv
/*
  Constants, types and timing for the codec control word sender.
  Assumes a single 125 MHz system clock; the package carries no logic.
*/
package codec_ctrl_pkg;

  // ==========================================================
  // word layout
  localparam int WORD_W = 16;
  localparam int SHIFT_W = 24;
  localparam int MSB_BIT = 23;
  localparam int PAD_W = SHIFT_W - WORD_W;
  localparam logic [4:0] BITS_PER_WORD = 5'h10;
  localparam logic [15:0] DUMMY_WORD = 16'h0000;

  // ==========================================================
  // port function select (1 = serial port, 0 = general purpose)
  localparam int PORT_W = 6;
  localparam logic [5:0] PORT_C_ALL_GPIO = 6'h00;
  localparam logic [5:0] PORT_C_RUN = 6'h3E;
  localparam logic [5:0] PORT_D_RUN = 6'h00;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CODEC_RESET_MS = 50;
  localparam int CODEC_RESET_CYC = (CODEC_RESET_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_DELAY_NS = 40;
  localparam int BIT_DELAY_RAW = (BIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_DELAY_CYC = (BIT_DELAY_RAW < 1) ? 1 : BIT_DELAY_RAW;
  localparam int CNT_W = 32;

  // ==========================================================
  // pins toward the codec
  typedef struct packed {
    logic codec_reset_n;
    logic control_select_n;
    logic control_shift_clock;
    logic control_serial_in;
  } codec_pins_t;

  localparam codec_pins_t PINS_RESET = '{codec_reset_n: 1'b0, control_select_n: 1'b1,
                                          control_shift_clock: 1'b0, control_serial_in: 1'b0};

  typedef enum logic [3:0] {
    ST_CODEC_RESET,
    ST_IDLE,
    ST_SELECT,
    ST_CLK_HIGH,
    ST_DATA,
    ST_HOLD,
    ST_CLK_LOW,
    ST_LOW_WAIT,
    ST_DESELECT
  } send_state_t;

endpackage : codec_ctrl_pkg

// ### codec_control_word_sender.sv
/*
  Codec control word sender: holds the codec in reset, then shifts a dummy
  all-zero update and the configured update out over select, clock and data
  pins, and afterwards sends one update per request.
  Assumes request and words come from logic on clk_i; no input needs syncing.
*/
// Summary of operation
// R1: drive select low before the first control bit of an update.
// R2: return select high after both words are shifted out.
// R3: each update sends upper word then lower word in one select window.
// R4: per bit, raise control clock first, then present the data bit.
// R5: data bit is the current most significant bit, MSB first.
// R6: wait a fixed delay after presenting data before changing the clock.
// R7: drive clock low to end the bit, then shift word left one.
// R8: exactly sixteen bit cycles per word, then next word or finish.
// R9: word held left-justified in a 24-bit register, bit 23 tested.
// R10: codec takes each bit on a falling control clock edge.
// R11: after codec reset send an all-zero update, then the configured one.
// R12: function select bit 1 gives pin to serial port, 0 makes it general.
// R13: codec reset, select, clock and data pins stay general purpose pins.
// R14: codec discards the first update after reset, accepts the second.
// R15: hold codec reset low at least 50 ms, release before any update.
// R16: codec accepts control only while select is low.
// R17: clock stays low between words; new request only after update completes.
`timescale 1ns/1ps

module codec_control_word_sender #(
  parameter int RESET_HOLD_CYCLES = codec_ctrl_pkg::CODEC_RESET_CYC // codec reset length
) (
  input wire logic clk_i, // 125 MHz system clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic codec_reset_req_i, // pulse: restart codec reset sequence
  input wire logic update_req_i, // request one update
  input wire logic [15:0] upper_word_i, // configured upper control word
  input wire logic [15:0] lower_word_i, // configured lower control word
  output logic update_ready_o, // high while idle, when a request can be taken
  output logic busy_o, // reset or update in progress
  output logic update_done_o, // pulse when select returns high
  output logic init_done_o, // codec initialised, serial port pins live
  output codec_ctrl_pkg::codec_pins_t pins_o, // codec reset, select, clock, data
  output logic [5:0] port_c_function_select_o, // port C pin modes
  output logic [5:0] port_d_function_select_o // port D pin modes
);

  // ==========================================================
  // state
  codec_ctrl_pkg::send_state_t state_ff, nxt_state;
  logic [codec_ctrl_pkg::SHIFT_W-1:0] shift_ff, nxt_shift;
  logic [4:0] bit_cnt_ff, nxt_bit_cnt;
  logic [codec_ctrl_pkg::CNT_W-1:0] wait_ff, nxt_wait;
  logic lower_ff, nxt_lower;
  logic dummy_ff, nxt_dummy;
  logic init_ff, nxt_init;
  logic done_ff, nxt_done;
  logic [15:0] hold_lo_ff, nxt_hold_lo;
  codec_ctrl_pkg::codec_pins_t pins_ff, nxt_pins;
  logic [5:0] pc_ff, nxt_pc;
  logic [5:0] pd_ff, nxt_pd;

  // left-justify a word so its MSB sits at the tested bit
  function automatic logic [codec_ctrl_pkg::SHIFT_W-1:0] justify(input logic [15:0] w);
    justify = {w, {codec_ctrl_pkg::PAD_W{1'b0}}};
  endfunction

  localparam logic [codec_ctrl_pkg::CNT_W-1:0] RESET_LAST = codec_ctrl_pkg::CNT_W'(RESET_HOLD_CYCLES - 1);
  localparam logic [codec_ctrl_pkg::CNT_W-1:0] DELAY_LAST = codec_ctrl_pkg::CNT_W'(codec_ctrl_pkg::BIT_DELAY_CYC - 1);

  // requests only in idle, so an update never overlaps another
  assign update_ready_o = (state_ff == codec_ctrl_pkg::ST_IDLE); // R17
  assign busy_o = (state_ff != codec_ctrl_pkg::ST_IDLE);
  assign update_done_o = done_ff;
  assign init_done_o = init_ff;
  assign pins_o = pins_ff;
  assign port_c_function_select_o = pc_ff;
  assign port_d_function_select_o = pd_ff;

  // ==========================================================
  // next-state logic
  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_wait = wait_ff;
    nxt_lower = lower_ff;
    nxt_dummy = dummy_ff;
    nxt_init = init_ff;
    nxt_done = 1'b0;
    nxt_hold_lo = hold_lo_ff;
    nxt_pins = pins_ff;
    nxt_pc = pc_ff;
    nxt_pd = codec_ctrl_pkg::PORT_D_RUN; // R13
    unique case (state_ff)
      codec_ctrl_pkg::ST_CODEC_RESET: begin
        // select is asserted during reset as well, clock idles low
        nxt_pins.codec_reset_n = 1'b0;
        nxt_pins.control_select_n = 1'b0;
        nxt_pins.control_shift_clock = 1'b0;
        if (wait_ff >= RESET_LAST) begin
          nxt_pins.codec_reset_n = 1'b1; // R15
          nxt_wait = '0;
          nxt_dummy = 1'b1; // R11
          nxt_shift = justify(codec_ctrl_pkg::DUMMY_WORD); // R11
          nxt_hold_lo = codec_ctrl_pkg::DUMMY_WORD;
          nxt_lower = 1'b0;
          nxt_bit_cnt = '0;
          nxt_state = codec_ctrl_pkg::ST_SELECT;
        end else begin
          nxt_wait = wait_ff + 1'b1; // R15
        end
      end
      codec_ctrl_pkg::ST_IDLE: begin
        nxt_pins.control_shift_clock = 1'b0; // R17
        nxt_pins.control_select_n = 1'b1;
        if (update_req_i) begin
          nxt_shift = justify(upper_word_i); // R9
          nxt_hold_lo = lower_word_i;
          nxt_lower = 1'b0;
          nxt_bit_cnt = '0;
          nxt_state = codec_ctrl_pkg::ST_SELECT;
        end
      end
      codec_ctrl_pkg::ST_SELECT: begin
        nxt_pins.control_select_n = 1'b0; // R1
        nxt_state = codec_ctrl_pkg::ST_CLK_HIGH;
      end
      codec_ctrl_pkg::ST_CLK_HIGH: begin
        // data follows this rising edge; the codec samples on the falling edge
        nxt_pins.control_shift_clock = 1'b1; // R4 R10
        nxt_state = codec_ctrl_pkg::ST_DATA;
      end
      codec_ctrl_pkg::ST_DATA: begin
        nxt_pins.control_serial_in = shift_ff[codec_ctrl_pkg::MSB_BIT]; // R5 R9
        nxt_wait = '0;
        nxt_state = codec_ctrl_pkg::ST_HOLD;
      end
      codec_ctrl_pkg::ST_HOLD: begin
        if (wait_ff >= DELAY_LAST) begin
          nxt_state = codec_ctrl_pkg::ST_CLK_LOW; // R6
        end else begin
          nxt_wait = wait_ff + 1'b1; // R6
        end
      end
      codec_ctrl_pkg::ST_CLK_LOW: begin
        nxt_pins.control_shift_clock = 1'b0; // R7
        nxt_shift = {shift_ff[codec_ctrl_pkg::SHIFT_W-2:0], 1'b0}; // R7
        nxt_bit_cnt = bit_cnt_ff + 1'b1;
        nxt_wait = '0;
        nxt_state = codec_ctrl_pkg::ST_LOW_WAIT;
      end
      codec_ctrl_pkg::ST_LOW_WAIT: begin
        // the low wait repeats the hold delay, so the clock is low 6 cycles against 7 high
        if (wait_ff < DELAY_LAST) begin
          nxt_wait = wait_ff + 1'b1;
        end else if (bit_cnt_ff != codec_ctrl_pkg::BITS_PER_WORD) begin
          nxt_state = codec_ctrl_pkg::ST_CLK_HIGH; // R8
        end else if (!lower_ff) begin
          nxt_lower = 1'b1; // R3
          nxt_bit_cnt = '0;
          nxt_shift = justify(hold_lo_ff); // R3 R9
          nxt_state = codec_ctrl_pkg::ST_CLK_HIGH;
        end else begin
          nxt_state = codec_ctrl_pkg::ST_DESELECT; // R8
        end
      end
      codec_ctrl_pkg::ST_DESELECT: begin
        nxt_pins.control_select_n = 1'b1; // R2 R16
        nxt_done = 1'b1;
        if (dummy_ff) begin
          // the codec drops the first update, so the real one follows
          nxt_dummy = 1'b0; // R11 R14
          nxt_shift = justify(upper_word_i); // R11
          nxt_hold_lo = lower_word_i;
          nxt_lower = 1'b0;
          nxt_bit_cnt = '0;
          nxt_state = codec_ctrl_pkg::ST_SELECT;
        end else begin
          nxt_init = 1'b1;
          nxt_pc = codec_ctrl_pkg::PORT_C_RUN; // R12 R13
          nxt_state = codec_ctrl_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = codec_ctrl_pkg::ST_CODEC_RESET;
      end
    endcase
    // a restart request overrides anything in flight
    if (codec_reset_req_i) begin
      nxt_state = codec_ctrl_pkg::ST_CODEC_RESET;
      nxt_wait = '0;
      nxt_init = 1'b0;
      nxt_pc = codec_ctrl_pkg::PORT_C_ALL_GPIO; // R12
      nxt_pins = codec_ctrl_pkg::PINS_RESET;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= codec_ctrl_pkg::ST_CODEC_RESET;
      shift_ff <= '0;
      bit_cnt_ff <= '0;
      wait_ff <= '0;
      lower_ff <= 1'b0;
      dummy_ff <= 1'b0;
      init_ff <= 1'b0;
      done_ff <= 1'b0;
      hold_lo_ff <= '0;
      pins_ff <= codec_ctrl_pkg::PINS_RESET;
      pc_ff <= codec_ctrl_pkg::PORT_C_ALL_GPIO;
      pd_ff <= codec_ctrl_pkg::PORT_D_RUN;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      bit_cnt_ff <= nxt_bit_cnt;
      wait_ff <= nxt_wait;
      lower_ff <= nxt_lower;
      dummy_ff <= nxt_dummy;
      init_ff <= nxt_init;
      done_ff <= nxt_done;
      hold_lo_ff <= nxt_hold_lo;
      pins_ff <= nxt_pins;
      pc_ff <= nxt_pc;
      pd_ff <= nxt_pd;
    end
  end

endmodule // codec_control_word_sender

// ### sender_assertions.sv
/* port checker for the codec control word sender
   assumes binding to codec_control_word_sender */
`timescale 1ns/1ps
module sender_assertions #(
  parameter int RESET_HOLD_CYCLES = 20 // codec reset length
) (
  input wire logic clk_i, // clock
  input wire logic sys_rst_i, // reset
  input wire logic update_ready_o, // idle
  input wire logic busy_o, // busy
  input wire logic update_done_o, // done pulse
  input wire codec_ctrl_pkg::codec_pins_t pins_o, // codec pins
  input wire logic [5:0] port_d_function_select_o, // port d modes
  input wire logic [5:0] port_c_function_select_o // port c modes
);
  logic [5:0] bits_ff, nxt_bits;
  logic [31:0] rlo_ff, nxt_rlo;
  logic sck_ff;
  wire sck = pins_o.control_shift_clock;
  wire sel = pins_o.control_select_n;
  wire rn = pins_o.codec_reset_n;
  // ==========================================
  // counters: clock rises per window, reset low time
  always_comb begin
    nxt_bits = (sel || !rn) ? 6'h00 : bits_ff + {5'h00, sck && !sck_ff};
    nxt_rlo = rn ? 32'h0 : rlo_ff + 32'h1;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bits_ff <= 6'h00;
      rlo_ff <= 32'h0;
      sck_ff <= 1'b0;
    end else begin
      bits_ff <= nxt_bits;
      rlo_ff <= nxt_rlo;
      sck_ff <= sck;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence hi_s; sck[*7]; endsequence
  sequence lo_s; (!sck)[*6]; endsequence
  sel_first_a: assert property ($rose(sck) |-> !sel) else $error("clock rose while deselected");
  // done is registered on the same edge that raises select, so both show in one cycle
  done_after_a: assert property ($rose(sel) && rn |-> update_done_o) else $error("no done pulse");
  clk_high_a: assert property ($rose(sck) |-> hi_s ##1 !sck) else $error("bad high phase");
  data_hold_a: assert property ($rose(sck) |-> ##2 $stable(pins_o.control_serial_in)[*5])
    else $error("data moved in hold");
  data_when_a: assert property ($changed(pins_o.control_serial_in) && rn |-> sck) else $error("data moved low");
  clk_low_a: assert property ($fell(sck) |-> lo_s) else $error("bad low phase");
  bit_count_a: assert property ($rose(sel) && rn |-> bits_ff == 6'h20) else $error("not 32 bits");
  rst_hold_a: assert property ($rose(rn) |-> rlo_ff >= RESET_HOLD_CYCLES) else $error("reset too short");
  idle_quiet_a: assert property (update_ready_o |-> sel && !sck && !busy_o) else $error("idle not quiet");
  pin_mode_a: assert property (port_d_function_select_o == 6'h00 && !port_c_function_select_o[0])
    else $error("control pins not general");
endmodule // sender_assertions
bind codec_control_word_sender sender_assertions #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) chk_u (.clk_i, .sys_rst_i,
  .update_ready_o, .busy_o, .update_done_o, .pins_o, .port_d_function_select_o, .port_c_function_select_o);

// ### codec_port_model.sv
/* codec control port model: collects 32 bits per select window
   assumes pins are oversampled by the system clock */
`timescale 1ns/1ps
module codec_port_model (
  input wire logic clk_i, // system clock
  input wire codec_ctrl_pkg::codec_pins_t pins_i, // codec pins
  output logic [31:0] word_o, // accepted update
  output logic got_o // accepted pulse
);
  logic [31:0] sh;
  logic prev_sck, prev_sel, armed;
  // bit taken at end of high phase, where it is settled
  always @(posedge clk_i) begin
    got_o <= 1'b0;
    prev_sck <= pins_i.control_shift_clock;
    prev_sel <= pins_i.control_select_n;
    if (!pins_i.codec_reset_n) begin
      armed <= 1'b0;
      sh <= 32'h0;
    end else if (!pins_i.control_select_n && prev_sck && !pins_i.control_shift_clock) begin
      // bit belongs to the high phase that its rising clock edge opened
      sh <= {sh[30:0], pins_i.control_serial_in};
    end else if (pins_i.control_select_n && !prev_sel) begin
      armed <= 1'b1;
      got_o <= armed;
      word_o <= sh;
      sh <= 32'h0;
    end
  end
endmodule // codec_port_model

// ### testbench.sv
/* self-checking bench for the codec control word sender
   assumes the checker is bound and the model watches the pins */
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, codec_reset_req_i = 1'b0, update_req_i = 1'b0;
  logic [15:0] upper_word_i = 16'h0000, lower_word_i = 16'h0000;
  logic update_ready_o, busy_o, update_done_o, init_done_o, got;
  codec_ctrl_pkg::codec_pins_t pins_o;
  logic [5:0] port_c_function_select_o, port_d_function_select_o;
  logic [31:0] word, exp_q[$];
  int fails = 0, checks_done = 0;
  always #4 clk_i = ~clk_i;
  // short codec reset keeps the run brief
  codec_control_word_sender #(.RESET_HOLD_CYCLES(20)) dut_u (.clk_i, .sys_rst_i, .codec_reset_req_i,
    .update_req_i, .upper_word_i, .lower_word_i, .update_ready_o, .busy_o, .update_done_o, .init_done_o,
    .pins_o, .port_c_function_select_o, .port_d_function_select_o);
  codec_port_model model_u (.clk_i, .pins_i(pins_o), .word_o(word), .got_o(got));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // monitor: each accepted update against the oldest note
  always @(posedge clk_i) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) check(32'h0, 32'h1);
      else check(word, exp_q.pop_front());
    end
  end
  // one request; hold keeps it up for back-to-back
  task automatic send(input bit hold);
    logic [15:0] u, l;
    u = 16'($urandom);
    l = 16'($urandom);
    upper_word_i <= u;
    lower_word_i <= l;
    update_req_i <= 1'b1;
    repeat (2000) begin
      @(posedge clk_i);
      if (update_ready_o === 1'b1) break;
    end
    exp_q.push_back({u, l});
    if (!hold) update_req_i <= 1'b0;
  endtask
  task automatic drain;
    repeat (5000) begin
      @(posedge clk_i);
      if (exp_q.size() == 0 && update_ready_o === 1'b1) break;
    end
    check(32'(exp_q.size()), 32'h0);
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h13ABE451));
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    upper_word_i <= 16'hA5C3;
    lower_word_i <= 16'h0F81;
    exp_q.push_back(32'hA5C30F81);
    repeat (3) @(posedge clk_i);
    check({26'h0, port_c_function_select_o}, 32'h0);
    drain();
    check({31'h0, init_done_o}, 32'h1);
    check({26'h0, port_c_function_select_o}, 32'h3E);
    $display("test init done");
    repeat (3) begin
      send(1'b0);
      drain();
    end
    $display("test single done");
    repeat (3) send(1'b1);
    update_req_i <= 1'b0;
    drain();
    $display("test back to back done");
    // restart mid-update in a low phase; same words come out again
    send(1'b0);
    repeat (60) @(posedge clk_i);
    @(negedge pins_o.control_shift_clock);
    @(posedge clk_i);
    codec_reset_req_i <= 1'b1;
    @(posedge clk_i);
    codec_reset_req_i <= 1'b0;
    // pins fall back to general purpose while the codec is reset again
    @(posedge clk_i);
    check({26'h0, port_c_function_select_o}, 32'h0);
    check({31'h0, init_done_o}, 32'h0);
    drain();
    check({26'h0, port_c_function_select_o}, 32'h3E);
    $display("test codec restart done");
    tally_and_finish();
  end
endmodule // testbench
